// [rtl/io_space_pkg.sv]
package io_space_pkg;

  // ----------------------------------------------------------------------
  // address spaces
  // ----------------------------------------------------------------------
  localparam logic [7:0] IO_PORT_LAST    = 8'h3F;
  localparam logic [7:0] IO_BIT_LAST     = 8'h1F;
  localparam logic [7:0] DATA_IO_OFFSET  = 8'h20;
  localparam logic [7:0] DATA_IO_LAST    = 8'h5F;
  localparam logic [7:0] DATA_EXT_FIRST  = 8'h60;
  localparam logic [7:0] DATA_EXT_LAST   = 8'h7C;
  localparam int         STORE_DEPTH     = 96;

  // ----------------------------------------------------------------------
  // data-space addresses of implemented registers
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_B_PIN_INPUT   = 8'h23;
  localparam logic [7:0] ADDR_PORT_B_DIRECTION   = 8'h24;
  localparam logic [7:0] ADDR_PORT_B_OUTPUT      = 8'h25;
  localparam logic [7:0] ADDR_PORT_C_PIN_INPUT   = 8'h26;
  localparam logic [7:0] ADDR_PORT_C_DIRECTION   = 8'h27;
  localparam logic [7:0] ADDR_PORT_C_OUTPUT      = 8'h28;
  localparam logic [7:0] ADDR_PORT_D_PIN_INPUT   = 8'h29;
  localparam logic [7:0] ADDR_PORT_D_DIRECTION   = 8'h2A;
  localparam logic [7:0] ADDR_PORT_D_OUTPUT      = 8'h2B;
  localparam logic [7:0] ADDR_PORT_E_PIN_INPUT   = 8'h2C;
  localparam logic [7:0] ADDR_PORT_E_DIRECTION   = 8'h2D;
  localparam logic [7:0] ADDR_PORT_E_OUTPUT      = 8'h2E;
  localparam logic [7:0] ADDR_TIMER0_FLAGS       = 8'h35;
  localparam logic [7:0] ADDR_TIMER1_FLAGS       = 8'h36;
  localparam logic [7:0] ADDR_SCRATCH_BYTE_ONE   = 8'h39;
  localparam logic [7:0] ADDR_SCRATCH_BYTE_TWO   = 8'h3A;
  localparam logic [7:0] ADDR_SCRATCH_BYTE_THREE = 8'h3B;
  localparam logic [7:0] ADDR_EXTERNAL_IRQ_FLAGS = 8'h3C;
  localparam logic [7:0] ADDR_EXTERNAL_IRQ_MASK  = 8'h3D;
  localparam logic [7:0] ADDR_SCRATCH_BYTE_ZERO  = 8'h3E;
  localparam logic [7:0] ADDR_NVM_DATA_CONTROL   = 8'h3F;
  localparam logic [7:0] ADDR_NVM_DATA_BYTE      = 8'h40;
  localparam logic [7:0] ADDR_NVM_ADDRESS_LOW    = 8'h41;
  localparam logic [7:0] ADDR_NVM_ADDRESS_HIGH   = 8'h42;
  localparam logic [7:0] ADDR_TIMER_GLOBAL_CTRL  = 8'h43;
  localparam logic [7:0] ADDR_TIMER0_CONTROL_A   = 8'h44;
  localparam logic [7:0] ADDR_TIMER0_CONTROL_B   = 8'h45;
  localparam logic [7:0] ADDR_TIMER0_COUNT       = 8'h46;
  localparam logic [7:0] ADDR_TIMER0_COMPARE_A   = 8'h47;
  localparam logic [7:0] ADDR_TIMER0_COMPARE_B   = 8'h48;
  localparam logic [7:0] ADDR_PLL_CONTROL_STATUS = 8'h49;
  localparam logic [7:0] ADDR_SERIAL_PERIPH_CTRL = 8'h4C;
  localparam logic [7:0] ADDR_SERIAL_PERIPH_STAT = 8'h4D;
  localparam logic [7:0] ADDR_SERIAL_PERIPH_DATA = 8'h4E;
  localparam logic [7:0] ADDR_COMPARATOR_STATUS  = 8'h50;
  localparam logic [7:0] ADDR_SLEEP_CONTROL      = 8'h53;
  localparam logic [7:0] ADDR_RESET_CAUSE        = 8'h54;
  localparam logic [7:0] ADDR_CORE_CONTROL       = 8'h55;
  localparam logic [7:0] ADDR_SELF_PROGRAM_CTRL  = 8'h57;
  localparam logic [7:0] ADDR_STACK_POINTER_LOW  = 8'h5D;
  localparam logic [7:0] ADDR_STACK_POINTER_HIGH = 8'h5E;
  localparam logic [7:0] ADDR_CORE_STATUS_FLAGS  = 8'h5F;
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL   = 8'h60;
  localparam logic [7:0] ADDR_CLOCK_PRESCALE     = 8'h61;
  localparam logic [7:0] ADDR_POWER_REDUCTION    = 8'h64;
  localparam logic [7:0] ADDR_OSCILLATOR_TRIM    = 8'h66;
  localparam logic [7:0] ADDR_EXTERNAL_IRQ_SENSE = 8'h69;
  localparam logic [7:0] ADDR_TIMER0_IRQ_MASK    = 8'h6E;

  localparam logic [7:0] RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------------
  // kinds of access presented by the core
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE       = 4'b0000,
    OP_PORT_READ  = 4'b0001,
    OP_PORT_WRITE = 4'b0010,
    OP_MEM_READ   = 4'b0011,
    OP_MEM_WRITE  = 4'b0100,
    OP_SET_BIT    = 4'b0101,
    OP_CLEAR_BIT  = 4'b0110,
    OP_SKIP_ONE   = 4'b0111,
    OP_SKIP_ZERO  = 4'b1000
  } access_op_e;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_RW   = 2'b01,
    KIND_RO   = 2'b10,
    KIND_W1C  = 2'b11
  } reg_kind_e;

endpackage

// [rtl/io_address_map.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// data-space address to register kind and implemented-bit mask
// ------------------------------------------------------------------------
module io_address_map (
  input  wire logic [7:0]             data_addr,
  output io_space_pkg::reg_kind_e     kind,
  output logic      [7:0]             bit_mask
);

  always_comb begin
    kind     = io_space_pkg::KIND_NONE;
    bit_mask = 8'h00;
    unique case (data_addr)
      io_space_pkg::ADDR_PORT_B_PIN_INPUT,
      io_space_pkg::ADDR_PORT_C_PIN_INPUT,
      io_space_pkg::ADDR_PORT_D_PIN_INPUT: begin
        kind     = io_space_pkg::KIND_RO;
        bit_mask = 8'hFF;
      end
      io_space_pkg::ADDR_PORT_E_PIN_INPUT: begin
        kind     = io_space_pkg::KIND_RO;
        bit_mask = 8'h07;
      end
      io_space_pkg::ADDR_PORT_E_DIRECTION,
      io_space_pkg::ADDR_PORT_E_OUTPUT: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h07;
      end
      io_space_pkg::ADDR_TIMER0_FLAGS: begin
        kind     = io_space_pkg::KIND_W1C;
        bit_mask = 8'h07;
      end
      io_space_pkg::ADDR_TIMER1_FLAGS: begin
        kind     = io_space_pkg::KIND_W1C;
        bit_mask = 8'h27;
      end
      io_space_pkg::ADDR_EXTERNAL_IRQ_FLAGS: begin
        kind     = io_space_pkg::KIND_W1C;
        bit_mask = 8'h0F;
      end
      io_space_pkg::ADDR_EXTERNAL_IRQ_MASK,
      io_space_pkg::ADDR_NVM_DATA_CONTROL,
      io_space_pkg::ADDR_NVM_ADDRESS_HIGH: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h0F;
      end
      io_space_pkg::ADDR_TIMER_GLOBAL_CTRL: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'hC1;
      end
      io_space_pkg::ADDR_TIMER0_CONTROL_A: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'hF3;
      end
      io_space_pkg::ADDR_TIMER0_CONTROL_B: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'hCF;
      end
      io_space_pkg::ADDR_PLL_CONTROL_STATUS: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h07;
      end
      io_space_pkg::ADDR_SERIAL_PERIPH_STAT: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'hC1;
      end
      io_space_pkg::ADDR_COMPARATOR_STATUS: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'hF7;
      end
      io_space_pkg::ADDR_RESET_CAUSE,
      io_space_pkg::ADDR_SLEEP_CONTROL: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h0F;
      end
      io_space_pkg::ADDR_CORE_CONTROL: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h93;
      end
      io_space_pkg::ADDR_SELF_PROGRAM_CTRL: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'hDF;
      end
      io_space_pkg::ADDR_CLOCK_PRESCALE: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h8F;
      end
      io_space_pkg::ADDR_OSCILLATOR_TRIM: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h7F;
      end
      io_space_pkg::ADDR_TIMER0_IRQ_MASK: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'h07;
      end
      io_space_pkg::ADDR_PORT_B_DIRECTION,
      io_space_pkg::ADDR_PORT_B_OUTPUT,
      io_space_pkg::ADDR_PORT_C_DIRECTION,
      io_space_pkg::ADDR_PORT_C_OUTPUT,
      io_space_pkg::ADDR_PORT_D_DIRECTION,
      io_space_pkg::ADDR_PORT_D_OUTPUT,
      io_space_pkg::ADDR_SCRATCH_BYTE_ONE,
      io_space_pkg::ADDR_SCRATCH_BYTE_TWO,
      io_space_pkg::ADDR_SCRATCH_BYTE_THREE,
      io_space_pkg::ADDR_SCRATCH_BYTE_ZERO,
      io_space_pkg::ADDR_NVM_DATA_BYTE,
      io_space_pkg::ADDR_NVM_ADDRESS_LOW,
      io_space_pkg::ADDR_TIMER0_COUNT,
      io_space_pkg::ADDR_TIMER0_COMPARE_A,
      io_space_pkg::ADDR_TIMER0_COMPARE_B,
      io_space_pkg::ADDR_SERIAL_PERIPH_CTRL,
      io_space_pkg::ADDR_SERIAL_PERIPH_DATA,
      io_space_pkg::ADDR_STACK_POINTER_LOW,
      io_space_pkg::ADDR_STACK_POINTER_HIGH,
      io_space_pkg::ADDR_CORE_STATUS_FLAGS,
      io_space_pkg::ADDR_WATCHDOG_CONTROL,
      io_space_pkg::ADDR_POWER_REDUCTION,
      io_space_pkg::ADDR_EXTERNAL_IRQ_SENSE: begin
        kind     = io_space_pkg::KIND_RW;
        bit_mask = 8'hFF;
      end
      default: begin
        kind     = io_space_pkg::KIND_NONE;
        bit_mask = 8'h00;
      end
    endcase
  end

endmodule // io_address_map

// [rtl/pin_sync.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// two-stage synchroniser for the port pin levels
// ------------------------------------------------------------------------
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s state_reg;
  sync_s state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.first  = async_in;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else if (enable) begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.second;

endmodule // pin_sync

// [rtl/io_space_address_decode.sv]
`timescale 1ns/1ps

// Contract
// RULE1: software writes zero into reserved bits whenever it writes a register.
// RULE2: software never writes a reserved I/O address.
// RULE3: bit set and bit clear work on I/O addresses 0x00 to 0x1F and do nothing elsewhere.
// RULE4: in that range any single bit can be tested for the skip-if-one and skip-if-zero tests.
// RULE5: some status flags clear when a one is written and stay when a zero is written.
// RULE6: a bit set or clear changes only the addressed bit, never writing back the others.
// RULE7: port read and port write reach I/O addresses 0x00 to 0x3F, the 64 encodable places.
// RULE8: a load or store reaches an I/O register at its I/O address plus 0x20.
// RULE9: extended registers from data address 0x60 are reached only by loads and stores.
// RULE10: writes to reserved addresses and bits are ignored, and reads of them return zero.
module io_space_address_decode (
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  input  wire logic                     clock_enable,
  input  wire io_space_pkg::access_op_e access_op,
  input  wire logic [7:0]               access_addr,
  input  wire logic [2:0]               access_bit,
  input  wire logic [7:0]               write_data,
  input  wire logic [7:0]               port_b_pins,
  input  wire logic [7:0]               port_c_pins,
  input  wire logic [7:0]               port_d_pins,
  input  wire logic [2:0]               port_e_pins,
  input  wire logic [2:0]               timer0_flag_events,
  input  wire logic [7:0]               timer1_flag_events,
  input  wire logic [3:0]               external_irq_events,
  output logic      [7:0]               read_data,
  output logic                          read_valid,
  output logic                          skip_result,
  output logic                          skip_valid,
  output logic                          access_ignored,
  output logic [7:0]                    port_b_direction,
  output logic [7:0]                    port_b_output,
  output logic [7:0]                    port_c_direction,
  output logic [7:0]                    port_c_output,
  output logic [7:0]                    port_d_direction,
  output logic [7:0]                    port_d_output,
  output logic [2:0]                    port_e_direction,
  output logic [2:0]                    port_e_output
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef logic [7:0] byte_t;

  typedef struct packed {
    byte_t [io_space_pkg::STORE_DEPTH-1:0] store;
    byte_t                                 read_data;
    logic                                  read_valid;
    logic                                  skip_result;
    logic                                  skip_valid;
    logic                                  access_ignored;
  } decode_s;

  decode_s state_reg;
  decode_s state_next;

  // ----------------------------------------------------------------------
  // address translation
  // ----------------------------------------------------------------------
  function automatic logic is_port_op(io_space_pkg::access_op_e op);
    return op == io_space_pkg::OP_PORT_READ  || op == io_space_pkg::OP_PORT_WRITE
        || op == io_space_pkg::OP_SET_BIT    || op == io_space_pkg::OP_CLEAR_BIT
        || op == io_space_pkg::OP_SKIP_ONE   || op == io_space_pkg::OP_SKIP_ZERO;
  endfunction

  function automatic logic is_bit_op(io_space_pkg::access_op_e op);
    return op == io_space_pkg::OP_SET_BIT  || op == io_space_pkg::OP_CLEAR_BIT
        || op == io_space_pkg::OP_SKIP_ONE || op == io_space_pkg::OP_SKIP_ZERO;
  endfunction

  // port-style ops carry an I/O address, memory ops a data-space address
  logic  addr_ok;
  byte_t data_addr;

  always_comb begin
    data_addr = access_addr;
    addr_ok   = 1'b0;
    if (is_bit_op(access_op)) begin
      data_addr = 8'(access_addr + io_space_pkg::DATA_IO_OFFSET); // RULE8
      addr_ok   = access_addr <= io_space_pkg::IO_BIT_LAST; // RULE3 RULE4
    end else if (is_port_op(access_op)) begin
      data_addr = 8'(access_addr + io_space_pkg::DATA_IO_OFFSET); // RULE8
      addr_ok   = access_addr <= io_space_pkg::IO_PORT_LAST; // RULE7 RULE9
    end else if (access_op != io_space_pkg::OP_NONE) begin
      addr_ok   = access_addr >= io_space_pkg::DATA_IO_OFFSET
               && access_addr <= io_space_pkg::DATA_EXT_LAST; // RULE9
    end
  end

  io_space_pkg::reg_kind_e kind;
  byte_t                   bit_mask;

  io_address_map u_map (
    .data_addr (data_addr),
    .kind      (kind),
    .bit_mask  (bit_mask)
  );

  // ----------------------------------------------------------------------
  // pin inputs, two flops each
  // ----------------------------------------------------------------------
  logic [26:0] pins_sync;

  pin_sync #(.WIDTH(27)) u_pins (
    .clock    (clock),
    .reset_n  (reset_n),
    .enable   (clock_enable),
    .async_in ({port_e_pins, port_d_pins, port_c_pins, port_b_pins}),
    .sync_out (pins_sync)
  );

  // extended registers sit above the 64 standard slots, else 0x64 would alias 0x24
  function automatic int unsigned slot(byte_t addr);
    return (addr[6:5] == 2'b11) ? 64 + int'(addr[4:0]) : int'(addr[5:0]) ^ 32;
  endfunction

  // pin registers read the synchronised levels, not the store
  byte_t current;

  always_comb begin
    unique case (data_addr)
      io_space_pkg::ADDR_PORT_B_PIN_INPUT: current = pins_sync[7:0];
      io_space_pkg::ADDR_PORT_C_PIN_INPUT: current = pins_sync[15:8];
      io_space_pkg::ADDR_PORT_D_PIN_INPUT: current = pins_sync[23:16];
      io_space_pkg::ADDR_PORT_E_PIN_INPUT: current = {5'b0_0000, pins_sync[26:24]};
      default:                             current = state_reg.store[slot(data_addr)];
    endcase
  end

  // ----------------------------------------------------------------------
  // access and flag update
  // ----------------------------------------------------------------------
  logic  mapped;
  byte_t one_bit;
  byte_t clear_mask;

  always_comb begin
    state_next                = state_reg;
    state_next.read_valid     = 1'b0;
    state_next.skip_valid     = 1'b0;
    state_next.access_ignored = 1'b0;
    mapped                    = addr_ok && kind != io_space_pkg::KIND_NONE;
    one_bit                   = byte_t'(8'h01 << access_bit);
    clear_mask                = 8'h00;

    if (access_op != io_space_pkg::OP_NONE && !mapped) begin
      state_next.access_ignored = 1'b1; // RULE10 RULE2
      if (access_op == io_space_pkg::OP_PORT_READ || access_op == io_space_pkg::OP_MEM_READ) begin
        state_next.read_data  = 8'h00; // RULE10
        state_next.read_valid = 1'b1;
      end
      if (access_op == io_space_pkg::OP_SKIP_ONE || access_op == io_space_pkg::OP_SKIP_ZERO) begin
        state_next.skip_result = 1'b0;
        state_next.skip_valid  = 1'b1;
      end
    end else if (mapped) begin
      unique case (access_op)
        io_space_pkg::OP_PORT_READ, io_space_pkg::OP_MEM_READ: begin
          state_next.read_data  = current & bit_mask; // RULE10
          state_next.read_valid = 1'b1;
        end
        io_space_pkg::OP_PORT_WRITE, io_space_pkg::OP_MEM_WRITE: begin
          if (kind == io_space_pkg::KIND_W1C) begin
            clear_mask = write_data & bit_mask; // RULE5
          end else if (kind == io_space_pkg::KIND_RW) begin
            state_next.store[slot(data_addr)] = write_data & bit_mask; // RULE10 RULE1
          end
        end
        io_space_pkg::OP_SET_BIT: begin
          // only the addressed bit moves, neighbouring flags untouched
          if (kind == io_space_pkg::KIND_W1C) begin
            clear_mask = one_bit & bit_mask; // RULE6
          end else if (kind == io_space_pkg::KIND_RW) begin
            state_next.store[slot(data_addr)] =
              state_reg.store[slot(data_addr)] | (one_bit & bit_mask); // RULE6
          end
        end
        io_space_pkg::OP_CLEAR_BIT: begin
          // writing zero to a flag bit leaves it as it is
          if (kind == io_space_pkg::KIND_RW) begin
            state_next.store[slot(data_addr)] =
              state_reg.store[slot(data_addr)] & ~one_bit; // RULE6
          end
        end
        io_space_pkg::OP_SKIP_ONE: begin
          state_next.skip_result = |(current & bit_mask & one_bit); // RULE4
          state_next.skip_valid  = 1'b1;
        end
        io_space_pkg::OP_SKIP_ZERO: begin
          state_next.skip_result = ~|(current & bit_mask & one_bit); // RULE4
          state_next.skip_valid  = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // flag events: set beats a clear in the same cycle
    state_next.store[slot(io_space_pkg::ADDR_TIMER0_FLAGS)] =
      (state_reg.store[slot(io_space_pkg::ADDR_TIMER0_FLAGS)]
       & ~((data_addr == io_space_pkg::ADDR_TIMER0_FLAGS) ? clear_mask : 8'h00))
      | {5'b0_0000, timer0_flag_events}; // RULE5
    state_next.store[slot(io_space_pkg::ADDR_TIMER1_FLAGS)] =
      (state_reg.store[slot(io_space_pkg::ADDR_TIMER1_FLAGS)]
       & ~((data_addr == io_space_pkg::ADDR_TIMER1_FLAGS) ? clear_mask : 8'h00))
      | (timer1_flag_events & 8'h27); // RULE5
    state_next.store[slot(io_space_pkg::ADDR_EXTERNAL_IRQ_FLAGS)] =
      (state_reg.store[slot(io_space_pkg::ADDR_EXTERNAL_IRQ_FLAGS)]
       & ~((data_addr == io_space_pkg::ADDR_EXTERNAL_IRQ_FLAGS) ? clear_mask : 8'h00))
      | {4'b0000, external_irq_events}; // RULE5
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else if (clock_enable) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign read_data        = state_reg.read_data;
  assign read_valid       = state_reg.read_valid;
  assign skip_result      = state_reg.skip_result;
  assign skip_valid       = state_reg.skip_valid;
  assign access_ignored   = state_reg.access_ignored;
  assign port_b_direction = state_reg.store[slot(io_space_pkg::ADDR_PORT_B_DIRECTION)];
  assign port_b_output    = state_reg.store[slot(io_space_pkg::ADDR_PORT_B_OUTPUT)];
  assign port_c_direction = state_reg.store[slot(io_space_pkg::ADDR_PORT_C_DIRECTION)];
  assign port_c_output    = state_reg.store[slot(io_space_pkg::ADDR_PORT_C_OUTPUT)];
  assign port_d_direction = state_reg.store[slot(io_space_pkg::ADDR_PORT_D_DIRECTION)];
  assign port_d_output    = state_reg.store[slot(io_space_pkg::ADDR_PORT_D_OUTPUT)];
  assign port_e_direction = state_reg.store[slot(io_space_pkg::ADDR_PORT_E_DIRECTION)][2:0];
  assign port_e_output    = state_reg.store[slot(io_space_pkg::ADDR_PORT_E_OUTPUT)][2:0];

endmodule // io_space_address_decode

// [testbench/io_decode_chk.sv]
`timescale 1ns/1ps
// ------
// port-level checks
// ------
module io_decode_chk (
  input wire logic                     clock,
  input wire logic                     reset_n,
  input wire logic                     clock_enable,
  input wire io_space_pkg::access_op_e access_op,
  input wire logic [7:0]               access_addr,
  input wire logic [2:0]               access_bit,
  input wire logic [7:0]               write_data,
  input wire logic                     read_valid,
  input wire logic                     skip_valid,
  input wire logic                     access_ignored,
  input wire logic [7:0]               port_b_output
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire pr = clock_enable && access_op == io_space_pkg::OP_PORT_READ;
  wire pw = clock_enable && access_op == io_space_pkg::OP_PORT_WRITE;
  wire mw = clock_enable && access_op == io_space_pkg::OP_MEM_WRITE;
  wire sb = clock_enable && access_op == io_space_pkg::OP_SET_BIT;
  wire sk = clock_enable && access_op inside {io_space_pkg::OP_SKIP_ONE,
    io_space_pkg::OP_SKIP_ZERO};
  read_answer_a: assert property (pr |=> read_valid)
    else $error("port read not answered");
  skip_answer_a: assert property (sk |=> skip_valid)
    else $error("skip test not answered");
  bit_range_a: assert property (sb && access_addr > 8'h1F |=> access_ignored)
    else $error("bit op beyond range not ignored");
  port_range_a: assert property ((pr || pw) && access_addr > 8'h3F |=> access_ignored)
    else $error("port op beyond range not ignored");
  store_offset_a: assert property (mw && access_addr == 8'h25 |=>
    port_b_output == $past(write_data)) else $error("store missed offset register");
  port_write_a: assert property (pw && access_addr == 8'h05 |=>
    port_b_output == $past(write_data)) else $error("port write missed register");
  one_bit_set_a: assert property (sb && access_addr == 8'h05 |=>
    port_b_output == ($past(port_b_output) | (8'h01 << $past(access_bit))))
    else $error("bit set touched other bits");
  ext_reach_a: assert property (mw && access_addr == 8'h64 |=> !access_ignored)
    else $error("extended store refused");
  reserved_store_a: assert property (mw && access_addr == 8'h22 |=> access_ignored)
    else $error("reserved store not ignored");
  cover property (pr ##1 read_valid);
  cover property (sk ##1 skip_valid);
  cover property (sb ##1 access_ignored);
endmodule // io_decode_chk

// [testbench/core_model.sv]
`timescale 1ns/1ps
// ------
// core side: one access per call, then idle
// ------
module core_model (
  input  wire logic                clock,
  output io_space_pkg::access_op_e access_op,
  output logic [7:0]               access_addr,
  output logic [2:0]               access_bit,
  output logic [7:0]               write_data
);
  initial begin
    access_op = io_space_pkg::OP_NONE;
    access_addr = 8'h00;
    access_bit = 3'h0;
    write_data = 8'h00;
  end
  // held across exactly one taken edge; stale data inverted so it cannot pass by luck
  task automatic go(input io_space_pkg::access_op_e op, input logic [7:0] a,
                    input logic [2:0] b, input logic [7:0] d);
    @(negedge clock);
    access_op = op;
    access_addr = a;
    access_bit = b;
    write_data = d;
    @(negedge clock);
    access_op = io_space_pkg::OP_NONE;
    write_data = ~d;
  endtask
endmodule // core_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clock, reset_n, clock_enable, read_valid, skip_result, skip_valid, access_ignored;
  logic [7:0] port_b_pins, access_addr, write_data, read_data, port_b_output, d, port_b_direction;
  logic [2:0] timer0_flag_events, access_bit;
  io_space_pkg::access_op_e access_op;
  int fails, samples_checked, i;
  io_space_address_decode dut (.clock, .reset_n, .clock_enable, .access_op, .access_addr,
    .access_bit, .write_data, .port_b_pins, .port_c_pins(8'h00), .port_d_pins(8'h00),
    .port_e_pins(3'h0), .timer0_flag_events, .timer1_flag_events(8'h00),
    .external_irq_events(4'h0), .read_data, .read_valid, .skip_result, .skip_valid,
    .access_ignored, .port_b_direction, .port_b_output, .port_c_direction(),
    .port_c_output(), .port_d_direction(), .port_d_output(), .port_e_direction(),
    .port_e_output());
  core_model core (.clock, .access_op, .access_addr, .access_bit, .write_data);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input io_space_pkg::access_op_e op, input logic [7:0] a,
                    input logic [7:0] exp);
    core.go(op, a, 3'h0, 8'h00);
    chk({7'h00, read_valid}, 8'h01);
    chk(read_data, exp);
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    #100000;
    fails++;
    test_done;
  end
  initial begin
    reset_n = 1'b0;
    clock_enable = 1'b1;
    port_b_pins = 8'h00;
    timer0_flag_events = 3'h0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    i = $urandom(10);
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      if (i[0]) begin
        core.go(io_space_pkg::OP_PORT_WRITE, 8'h05, 3'h0, d);
      end else begin
        core.go(io_space_pkg::OP_MEM_WRITE, 8'h25, 3'h0, d);
      end
      chk(port_b_output, d);
      rd(io_space_pkg::OP_PORT_READ, 8'h05, d);
    end
    $display("store and port paths done");
    for (i = 0; i < 8; i++) begin
      d[i] = 1'b1;
      core.go(io_space_pkg::OP_SET_BIT, 8'h05, 3'(i), 8'h00);
      chk(port_b_output, d);
      core.go(io_space_pkg::OP_SKIP_ONE, 8'h05, 3'(i), 8'h00);
      chk({7'h00, skip_result}, 8'h01);
      d[i] = 1'b0;
      core.go(io_space_pkg::OP_CLEAR_BIT, 8'h05, 3'(i), 8'h00);
      chk(port_b_output, d);
      core.go(io_space_pkg::OP_SKIP_ZERO, 8'h05, 3'(i), 8'h00);
      chk({7'h00, skip_result}, 8'h01);
    end
    core.go(io_space_pkg::OP_SKIP_ONE, 8'h05, 3'h0, 8'h00);
    chk({7'h00, skip_result}, 8'h00);
    core.go(io_space_pkg::OP_SET_BIT, 8'h24, 3'h0, 8'h00);
    chk({7'h00, access_ignored}, 8'h01);
    rd(io_space_pkg::OP_MEM_READ, 8'h44, 8'h00);
    $display("bit access done");
    @(negedge clock);
    timer0_flag_events = 3'h7;
    @(negedge clock);
    timer0_flag_events = 3'h0;
    rd(io_space_pkg::OP_PORT_READ, 8'h15, 8'h07);
    core.go(io_space_pkg::OP_SET_BIT, 8'h15, 3'h1, 8'h00);
    rd(io_space_pkg::OP_PORT_READ, 8'h15, 8'h05);
    core.go(io_space_pkg::OP_PORT_WRITE, 8'h15, 3'h0, 8'h01);
    rd(io_space_pkg::OP_MEM_READ, 8'h35, 8'h04);
    $display("flag clearing done");
    d = 8'($urandom);
    core.go(io_space_pkg::OP_MEM_WRITE, 8'h64, 3'h0, d);
    chk(port_b_direction, 8'h00);
    rd(io_space_pkg::OP_MEM_READ, 8'h64, d);
    core.go(io_space_pkg::OP_MEM_WRITE, 8'h66, 3'h0, 8'hFF);
    rd(io_space_pkg::OP_MEM_READ, 8'h66, 8'h7F);
    rd(io_space_pkg::OP_PORT_READ, 8'h46, 8'h00);
    core.go(io_space_pkg::OP_MEM_WRITE, 8'h22, 3'h0, 8'hFF);
    chk({7'h00, access_ignored}, 8'h01);
    rd(io_space_pkg::OP_MEM_READ, 8'h22, 8'h00);
    port_b_pins = 8'($urandom);
    repeat (2) @(negedge clock);
    rd(io_space_pkg::OP_PORT_READ, 8'h03, port_b_pins);
    $display("extended and reserved done");
    test_done;
  end
endmodule // testbench
bind io_space_address_decode io_decode_chk chk (.clock, .reset_n, .clock_enable,
  .access_op, .access_addr, .access_bit, .write_data, .read_valid, .skip_valid,
  .access_ignored, .port_b_output);
